// *** verilog/spi_master_pkg.sv ***
// Constants and register layout of the serial master port
`default_nettype none
package spi_master_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_BUF    = 8'h08;
   localparam logic [7:0] OFF_IRQ    = 8'h0C;
   localparam logic [7:0] OFF_DIR    = 8'h10;
   // port_control_reg fields
   localparam int CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int CTRL_OVF  = 6;
   localparam int CTRL_EN   = 5;
   localparam int CTRL_CKP  = 4;
   localparam int CTRL_MODE = 0;
   // port_status_reg fields
   localparam int STAT_SMP = 7;
   localparam int STAT_CKE = 6;
   localparam int STAT_BF  = 0;
   // peripheral_irq_flags and pin_direction_bits fields
   localparam int IRQ_PORT = 0;
   localparam int DIR_SDI  = 0;
   localparam int DIR_SDO  = 1;
   localparam int DIR_SCK  = 2;
   // Reset values
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [2:0] DIR_RST    = 3'h7;
   // port_mode_select codes
   localparam logic [3:0] MODE_DIV4  = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TMR2  = 4'h3;
   // Half bit periods in pclk cycles for the three divided rates
   localparam int HALF_DIV4  = 2;
   localparam int HALF_DIV16 = 8;
   localparam int HALF_DIV64 = 32;
   // Bits per transfer and clock edges per transfer
   localparam int XFER_BITS  = 8;
   localparam int XFER_EDGES = 2 * XFER_BITS;
endpackage : spi_master_pkg
`default_nettype wire

// *** verilog/spi_master_port.sv ***
// Serial master port: APB registers, bit clock, shift engine
//
// How it works
// - Eight bits shift both ways together
// - Shift register moves MSb first
// - Buffer write starts transfer immediately
// - Done: byte to buffer, full and irq
// - Write while busy dropped, collision flag
// - Reading buffer clears full flag
// - Shift register reachable only via buffer
// - Enabled master mode takes over pins
// - Receive-only still samples input line
// - Bit clock Fosc/4, /16, /64, timer/2
// - Clock idle level follows polarity bit
// - Edge select presents data before edge
// - Sample phase picks middle or end
// - Sleep freezes transfer, resumes afterwards
// - Master alone makes the serial clock
// - Mode codes 0000..0011 pick the rates
// - Polarity one idles high, zero low
// - Overflow flag never set as master
//
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none
module spi_master_port
   import spi_master_pkg::*;
#(
   parameter int HALF4  = HALF_DIV4,
   parameter int HALF16 = HALF_DIV16,
   parameter int HALF64 = HALF_DIV64
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sleep,
   input  wire logic        timer2_pulse,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   output logic             sck,
   output logic             sck_oe,
   output logic             port_irq_flag
);

   // Divider counter must hold every half period
   if (HALF4 < 1 || HALF16 < 1 || HALF64 < 1 || HALF4 > 32 || HALF16 > 32 || HALF64 > 32)
   begin : g_bad_div
      $error("half period parameters must lie in 1..32");
   end

   typedef struct packed {
      logic        busy;
      logic        ph;
      logic [4:0]  edges;
      logic [4:0]  div;
      logic [7:0]  sr;
      logic        samp;
      logic [7:0]  buf_data;
      logic        bf;
      logic        irq;
      logic        write_collision_flag;
      logic        ovf;
      logic        en;
      logic        clock_idle_polarity;
      logic [3:0]  mode;
      logic        input_sample_phase;
      logic        cke;
      logic [2:0]  dir;
      logic [31:0] prdata;
   } state_t;

   state_t q, d;

   logic       acc;
   logic       wr;
   logic       rd;
   logic       master;
   logic       tick;
   logic [4:0] half_lim;
   logic [4:0] e;
   logic       mid;
   logic       shift;
   logic       in_bit;
   logic       mapped;
   logic [7:0] sr_new;

   // Zero wait state slave; unmapped words answer with an error
   assign pready  = 1'b1;
   assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_BUF) ||
                    (paddr == OFF_IRQ) || (paddr == OFF_DIR);
   assign pslverr = psel & penable & ~mapped;

   // Pin drive; data comes straight from a flip-flop, clock is polarity XOR phase flip-flop
   // MSb stands before first edge
   assign sdo           = q.sr[7];
   assign sck           = q.clock_idle_polarity ^ q.ph;
   assign sdo_oe        = master & ~q.dir[DIR_SDO];
   assign sck_oe        = master & ~q.dir[DIR_SCK];
   assign port_irq_flag = q.irq;
   assign prdata        = q.prdata;

   // Next state: software first, hardware events after so sets win
   always_comb begin
      d        = q;
      acc      = psel & penable & mapped;
      wr       = acc & pwrite;
      rd       = acc & ~pwrite;
      // pins owned in an enabled master mode
      master   = q.en & (q.mode[3:2] == 2'b00);
      // mode code picks the half period
      case (q.mode)
         MODE_DIV4:  half_lim = 5'(HALF4 - 1);
         MODE_DIV16: half_lim = 5'(HALF16 - 1);
         MODE_DIV64: half_lim = 5'(HALF64 - 1);
         default:    half_lim = 5'h00;
      endcase
      // divided rate or one timer pulse per half period
      tick     = q.busy & ~sleep &
                 ((q.mode == MODE_TMR2) ? timer2_pulse : (q.div == half_lim));
      e        = q.edges + 5'h01;
      mid      = q.cke ? e[0] : ~e[0];
      shift    = q.cke ? ~e[0] : ((e[0] && e != 5'h01) || e == 5'(XFER_EDGES));
      // end sampling takes the line at the shift edge itself
      in_bit   = (q.input_sample_phase | mid) ? sdi : q.samp;
      sr_new   = {q.sr[6:0], in_bit};

      // Read data is captured in the setup cycle
      if (psel && !penable && !pwrite) begin
         case (paddr)
            OFF_CTRL:   d.prdata = {24'h000000, q.write_collision_flag, q.ovf, q.en, q.clock_idle_polarity, q.mode};
            OFF_STATUS: d.prdata = {24'h000000, q.input_sample_phase, q.cke, 5'h00, q.bf};
            OFF_BUF:    d.prdata = {24'h000000, q.buf_data};
            OFF_IRQ:    d.prdata = {31'h00000000, q.irq};
            OFF_DIR:    d.prdata = {29'h00000000, q.dir};
            default:    d.prdata = 32'h00000000;
         endcase
      end

      // Register writes
      if (wr) begin
         case (paddr)
            OFF_CTRL: begin
               d.write_collision_flag = pwdata[CTRL_WRITE_COLLISION_FLAG];
               d.en   = pwdata[CTRL_EN];
               d.clock_idle_polarity  = pwdata[CTRL_CKP];
               d.mode = pwdata[CTRL_MODE +: 4];
            end
            OFF_STATUS: begin
               d.input_sample_phase = pwdata[STAT_SMP];
               d.cke = pwdata[STAT_CKE];
            end
            OFF_IRQ: d.irq = pwdata[IRQ_PORT];
            OFF_DIR: d.dir = pwdata[2:0];
            OFF_BUF: begin
               if (q.busy) begin
                  // collision drops the byte and flags it
                  d.write_collision_flag = 1'b1;
               end else begin
                  // the shift register loads only through the buffer
                  d.buf_data = pwdata[7:0];
                  if (master) begin
                     // a write is the only start trigger
                     d.sr    = pwdata[7:0];
                     d.busy  = 1'b1;
                     d.edges = 5'h00;
                     d.div   = 5'h00;
                     d.ph    = 1'b0;
                  end
               end
            end
            default: d.write_collision_flag = q.write_collision_flag;
         endcase
      end

      // buffer read empties the full flag
      if (rd && paddr == OFF_BUF) begin
         d.bf = 1'b0;
      end

      // Divider runs only inside a transfer and holds in sleep
      if (q.busy && !sleep && q.mode != MODE_TMR2) begin
         d.div = tick ? 5'h00 : q.div + 5'h01;
      end

      // every clock edge but the park on disable is made here
      if (tick) begin
         d.ph    = ~q.ph;
         d.edges = e;
         if (mid && !q.input_sample_phase) begin
            d.samp = sdi;
         end
         // MSb leaves first, new bit enters at the bottom
         // sampling ignores whether sdo is driven
         if (shift) begin
            d.sr = sr_new;
         end
         // sixteen edges move eight bits each way
         if (e == 5'(XFER_EDGES)) begin
            // received byte to buffer, flags raised
            d.busy     = 1'b0;
            d.edges    = 5'h00;
            d.ph       = 1'b0;
            d.buf_data = sr_new;
            d.bf       = 1'b1;
            d.irq      = 1'b1;
         end
      end

      // overflow has no source in master operation
      d.ovf = 1'b0;

      // disable aborts the transfer and parks the clock
      if (!q.en) begin
         d.busy  = 1'b0;
         d.edges = 5'h00;
         d.ph    = 1'b0;
         d.div   = 5'h00;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q          <= '0;
         q.en       <= CTRL_RST[CTRL_EN];
         q.clock_idle_polarity      <= CTRL_RST[CTRL_CKP];
         q.mode     <= CTRL_RST[3:0];
         q.input_sample_phase      <= STATUS_RST[STAT_SMP];
         q.cke      <= STATUS_RST[STAT_CKE];
         q.dir      <= DIR_RST;
      end else begin
         q <= d;
      end
   end

   // Checks on the design's own behaviour
   sequence s_buf_write_busy;
      psel && penable && pwrite && paddr == OFF_BUF && q.busy;
   endsequence

   sequence s_buf_write_idle;
      psel && penable && pwrite && paddr == OFF_BUF && !q.busy && master;
   endsequence

   sequence s_last_edge;
      tick && e == 5'(XFER_EDGES);
   endsequence

   property p_collision;
      @(posedge pclk) disable iff (!presetn)
      s_buf_write_busy |=> q.write_collision_flag && (q.buf_data == $past(q.buf_data, 1) || $past(tick && q.busy));
   endproperty
   a_collision: assert property (p_collision) else $error("busy write not flagged");

   property p_start;
      @(posedge pclk) disable iff (!presetn)
      s_buf_write_idle |=> q.busy && sdo == $past(pwdata[7]) && q.edges == 5'h00;
   endproperty
   a_start: assert property (p_start) else $error("write did not start transfer");

   property p_done;
      @(posedge pclk) disable iff (!presetn)
      s_last_edge |=> !q.busy && q.bf && q.irq && q.buf_data == $past(sr_new);
   endproperty
   a_done: assert property (p_done) else $error("completion flags missing");

   property p_read_clear;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && paddr == OFF_BUF && !tick |=> !q.bf;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read left full flag");

   property p_idle_level;
      @(posedge pclk) disable iff (!presetn)
      !q.busy |-> sck == q.clock_idle_polarity;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

   property p_sleep_hold;
      @(posedge pclk) disable iff (!presetn)
      q.busy && sleep && q.en |=> $stable(q.sr) && $stable(q.edges) && $stable(sck);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("transfer moved in sleep");

   property p_abort;
      @(posedge pclk) disable iff (!presetn)
      !q.en |=> !q.busy && q.edges == 5'h00 ##0 sck == q.clock_idle_polarity;
   endproperty
   a_abort: assert property (p_abort) else $error("disable did not abort");

   property p_no_ovf;
      @(posedge pclk) disable iff (!presetn)
      q.busy |=> !q.ovf;
   endproperty
   a_no_ovf: assert property (p_no_ovf) else $error("overflow set in master");

   property p_fast_rate;
      @(posedge pclk) disable iff (!presetn)
      q.busy && q.en && !sleep && q.mode == MODE_DIV4 && q.div == 5'h00 && HALF4 == 2
         |-> !tick ##1 tick;
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("fast rate wrong");

   property p_pins;
      @(posedge pclk) disable iff (!presetn)
      !q.en |-> !sdo_oe && !sck_oe;
   endproperty
   a_pins: assert property (p_pins) else $error("pins driven while disabled");

   property p_sdo_hold;
      @(posedge pclk) disable iff (!presetn)
      q.busy && !(tick && shift) |=> $stable(sdo);
   endproperty
   a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved off a shift edge");

   property p_shift_msb;
      @(posedge pclk) disable iff (!presetn)
      tick && shift |=> q.sr[7:1] == $past(q.sr[6:0]);
   endproperty
   a_shift_msb: assert property (p_shift_msb) else $error("shift not toward MSb");

   property p_mid_sample;
      @(posedge pclk) disable iff (!presetn)
      tick && mid && !q.input_sample_phase |=> q.samp == $past(sdi);
   endproperty
   a_mid_sample: assert property (p_mid_sample) else $error("mid sample missed");

endmodule : spi_master_port
`default_nettype wire

// *** tb/spi_slave_model.sv ***
// Behavioural serial slave on the far side of the port
`default_nettype none
module spi_slave_model (
   input  wire logic       sck,
   input  wire logic       sdo,
   input  wire logic       cke,
   input  wire logic       arm,
   input  wire logic [7:0] tx,
   output logic            sdi,
   output logic [7:0]      rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int         n = 16;
   logic [7:0] sh;
   logic       sdo_late;
   // Late copy, so a same-step sdo update is not seen
   assign #1 sdo_late = sdo;
   initial sdi = 1'h0;
   // Arming loads the reply, MSb out first
   always @(posedge arm) begin
      n = 0;
      sh = tx;
      sdi = tx[7];
   end
   always @(sck) begin
      if (arm && n < 16) begin
         n++;
         if (n[0] == cke)
            rx = {rx[6:0], sdo_late};
         else if (n > 1) begin
            sh = sh << 1;
            sdi = sh[7];
         end
         // Released line shows the inverse
         if (n == 16)
            sdi = ~sdi;
      end
   end
endmodule : spi_slave_model
`default_nettype wire

// *** tb/tb_spi_master_port.sv ***
// Self-checking bench for the serial master port
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_spi_master_port
   import spi_master_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        sleep = 0, timer2_pulse = 0, arm = 0, scke = 0, sdo_off = 0;
   logic [7:0]  paddr = 0, stx = 0, srx;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err, sdi, sdo, sdo_oe, sck, sck_oe, port_irq_flag;
   logic [1:0]  tcnt = 0;
   int          errors = 0, comparisons = 0, cycles = 0, edges = 0;
   int          hv[4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 0};

   spi_master_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleep, .timer2_pulse, .sdi, .sdo, .sdo_oe, .sck,
      .sck_oe, .port_irq_flag);
   // Released data line shows the inverse to the slave
   spi_slave_model slave (.sck(sck), .sdo(sdo_oe ? sdo : ~sdo), .cke(scke), .arm(arm), .tx(stx),
      .sdi(sdi), .rx(srx));

   always #2.5 pclk = ~pclk;
   // Timer pulse every fourth cycle
   always @(posedge pclk) begin
      tcnt <= tcnt + 2'h1;
      timer2_pulse <= (tcnt == 2'h3);
   end
   always @(sck) edges++;
   // Hang guard, far above the longest run
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wait_irq(output int n);
      n = 0;
      while (port_irq_flag !== 1'h1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_irq

   task automatic regs();
      apb(1'h0, OFF_CTRL, 32'h0);
      `CHK("ctrl", {24'h0, CTRL_RST}, rd)
      apb(1'h0, OFF_STATUS, 32'h0);
      `CHK("status", {24'h0, STATUS_RST}, rd)
      apb(1'h0, OFF_DIR, 32'h0);
      `CHK("dir", {29'h0, DIR_RST}, rd)
      apb(1'h0, 8'h14, 32'h0);
      `CHK("unmapped", 33'h100000000, {err, rd})
      $display("Register test done");
   endtask : regs

   task automatic xfer(input logic [3:0] m, input logic cp, ce, sm,
                       input logic [7:0] t, s, input int h);
      int n;
      arm <= 1'h0;
      scke <= ce;
      stx <= s;
      apb(1'h1, OFF_CTRL, {27'h0, cp, m});
      apb(1'h1, OFF_STATUS, {24'h0, sm, ce, 6'h0});
      apb(1'h1, OFF_IRQ, 32'h0);
      apb(1'h1, OFF_CTRL, {27'h1, cp, m});
      @(posedge pclk);
      `CHK("sck idle", cp, sck)
      edges = 0;
      arm <= 1'h1;
      apb(1'h1, OFF_BUF, {24'h0, t});
      wait_irq(n);
      if (h > 0) `CHK("latency", 16 * h + 1, n)
      `CHK("edges", 16, edges)
      apb(1'h0, OFF_STATUS, 32'h0);
      `CHK("full", 1'h1, rd[STAT_BF])
      apb(1'h0, OFF_BUF, 32'h0);
      `CHK("rx byte", {24'h0, s}, rd)
      `CHK("tx byte", sdo_off ? ~t : t, srx)
      apb(1'h0, OFF_STATUS, 32'h0);
      `CHK("full clr", 1'h0, rd[STAT_BF])
      $display("Transfer mode %0d done", m);
   endtask : xfer

   task automatic start(input logic [7:0] t, s);
      arm <= 1'h0;
      scke <= 1'h1;
      stx <= s;
      apb(1'h1, OFF_CTRL, 32'h20);
      apb(1'h1, OFF_STATUS, 32'h40);
      apb(1'h1, OFF_IRQ, 32'h0);
      arm <= 1'h1;
      apb(1'h1, OFF_BUF, {24'h0, t});
   endtask : start

   task automatic collide();
      int n;
      start(8'hA5, 8'h96);
      apb(1'h1, OFF_BUF, 32'h0F);
      wait_irq(n);
      apb(1'h0, OFF_CTRL, 32'h0);
      `CHK("collision", 32'hA0, rd)
      apb(1'h0, OFF_BUF, 32'h0);
      `CHK("buf kept", 32'h96, rd)
      `CHK("tx kept", 8'hA5, srx)
      apb(1'h1, OFF_CTRL, 32'h20);
      apb(1'h0, OFF_CTRL, 32'h0);
      `CHK("collision clr", 32'h20, rd)
      $display("Collision test done");
   endtask : collide

   task automatic freeze();
      int   n;
      logic s0;
      start(8'h5A, 8'hE1);
      repeat (10) @(posedge pclk);
      sleep <= 1'h1;
      @(posedge pclk);
      s0 = sck;
      repeat (39) @(posedge pclk);
      `CHK("sck frozen", s0, sck)
      `CHK("no finish", 1'h0, port_irq_flag)
      sleep <= 1'h0;
      wait_irq(n);
      `CHK("resume", 23, n)
      apb(1'h0, OFF_BUF, 32'h0);
      `CHK("sleep rx", 32'hE1, rd)
      $display("Sleep test done");
   endtask : freeze

   task automatic abort();
      int n;
      apb(1'h1, OFF_DIR, 32'h0);
      start(8'h33, 8'hCC);
      `CHK("pins", 2'h3, {sdo_oe, sck_oe})
      n = 0;
      while (sck !== 1'h1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      apb(1'h1, OFF_CTRL, 32'h0);
      repeat (40) @(posedge pclk);
      `CHK("abort", 2'h0, {sck, port_irq_flag})
      apb(1'h1, OFF_DIR, 32'h2);
      sdo_off = 1'h1;
      xfer(4'h0, 1'h0, 1'h1, 1'h0, 8'h3C, 8'hC3, HALF_DIV4);
      `CHK("rx only", 2'h1, {sdo_oe, sck_oe})
      $display("Abort test done");
   endtask : abort

   task automatic print_verdict();
      $display("Comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      regs();
      apb(1'h1, OFF_DIR, 32'h0);
      for (int m = 0; m < 4; m++) begin
         xfer(m[3:0], m[0], m == 0 || m == 3, m[0], 8'hA5 ^ m[7:0], 8'h69 + m[7:0], hv[m]);
      end
      collide();
      freeze();
      abort();
      print_verdict();
   end
endmodule : tb_spi_master_port
`default_nettype wire
